// ---- rtl/ppmi_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the pin pattern match block.
`ifndef PPMI_CFG_SVH
`define PPMI_CFG_SVH

`define PPMI_OFF_MASK      8'h00
`define PPMI_OFF_PATTERN   8'h04
`define PPMI_OFF_CONTROL   8'h08
`define PPMI_OFF_STATUS    8'h0C
`define PPMI_OFF_IRQ_MASK  8'h10
`define PPMI_OFF_PORT      8'h14
`define PPMI_OFF_QUAL      8'h18

`define PPMI_CTRL_ACTIVE_BIT   0
`define PPMI_CTRL_POL_BIT      1
`define PPMI_CTRL_WAKE_BIT     2
`define PPMI_STAT_FLAG_BIT     0
`define PPMI_IMASK_FLAG_BIT    0

`define PPMI_RST_MASK      8'h00
`define PPMI_RST_PATTERN   8'hFF
`define PPMI_RST_CONTROL   3'h0
`define PPMI_RST_IRQ_MASK  1'h0

`define PPMI_HOLD_CORE_CLOCKS  6
`define PPMI_HOLD_CYCLES       (`PPMI_HOLD_CORE_CLOCKS * 1)

`endif

// ---- rtl/ppmi_pkg.sv ----
// Types shared by the pin pattern match block.
package ppmi_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ppmi_bus_req_t;

   typedef struct packed {
      logic wake_en;
      logic polarity;
      logic active;
   } ppmi_ctrl_t;

   typedef enum logic [1:0] {
      PPMI_ST_IDLE = 2'b00,
      PPMI_ST_QUAL = 2'b01,
      PPMI_ST_HELD = 2'b10
   } ppmi_state_t;

endpackage

// ---- rtl/ppmi_sync.sv ----
// Two-flop synchroniser for the eight port pins.
`timescale 1ns/1ps
`default_nettype none
module ppmi_sync (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [7:0] pins_in,
   output logic [7:0]      pins_sync
);

   logic [7:0] meta_ff;
   logic [7:0] sync_ff;

   // The first stage is read by the second stage only.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_ff <= 8'hFF;
         sync_ff <= 8'hFF;
      end else begin
         meta_ff <= pins_in;
         sync_ff <= meta_ff;
      end
   end

   assign pins_sync = sync_ff;

endmodule
`default_nettype wire

// ---- rtl/ppmi_top.sv ----
// Pin pattern match interrupt: register port, match qualifier, sticky flag, interrupt and wake outputs.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ppmi_cfg.svh"
module ppmi_top (
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire ppmi_pkg::ppmi_bus_req_t bus_req,
   output logic [31:0]                  rd_data,
   input  wire logic [7:0]              port_pins,
   output logic                         irq,
   output logic                         wake_req
);

   localparam logic [2:0] HOLD_LAST = 3'(`PPMI_HOLD_CYCLES);

   logic [7:0]           pin_match_mask_ff;
   logic [7:0]           pin_match_pattern_ff;
   ppmi_pkg::ppmi_ctrl_t pin_match_control_ff;
   logic                 pin_match_flag_ff;
   logic                 irq_en_ff;
   logic                 irq_ff;
   logic                 wake_ff;
   logic [31:0]          rd_data_ff;
   ppmi_pkg::ppmi_state_t state_ff;
   logic [2:0]           cnt_ff;

   ppmi_pkg::ppmi_state_t nxt_state;
   logic [2:0]           nxt_cnt;
   logic                 nxt_flag;
   logic                 nxt_irq_en;
   logic [7:0]           nxt_mask;
   logic [7:0]           nxt_pattern;
   ppmi_pkg::ppmi_ctrl_t nxt_control;
   logic [31:0]          nxt_rd_data;

   logic [7:0]           sync_q;
   logic [7:0]           diff_w;
   logic                 equal_w;
   logic                 hit_w;
   logic                 match_w;
   logic                 set_evt;
   logic                 clr_w;

   logic                 sel_mask;
   logic                 sel_pattern;
   logic                 sel_control;
   logic                 sel_status;
   logic                 sel_imask;
   logic                 sel_port;
   logic                 sel_qual;
   logic                 wr_mask;
   logic                 wr_pattern;
   logic                 wr_control;
   logic                 wr_imask;
   logic [31:0]          rd_mux;

   // Pins come from outside the clock domain.
   ppmi_sync u_sync (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .pins_in   (port_pins),
      .pins_sync (sync_q)
   );

   // Address decode.
   assign sel_mask    = bus_req.addr == `PPMI_OFF_MASK;
   assign sel_pattern = bus_req.addr == `PPMI_OFF_PATTERN;
   assign sel_control = bus_req.addr == `PPMI_OFF_CONTROL;
   assign sel_status  = bus_req.addr == `PPMI_OFF_STATUS;
   assign sel_imask   = bus_req.addr == `PPMI_OFF_IRQ_MASK;
   assign sel_port    = bus_req.addr == `PPMI_OFF_PORT;
   assign sel_qual    = bus_req.addr == `PPMI_OFF_QUAL;

   assign wr_mask    = bus_req.wr & sel_mask;
   assign wr_pattern = bus_req.wr & sel_pattern;
   assign wr_control = bus_req.wr & sel_control;
   assign wr_imask   = bus_req.wr & sel_imask;
   assign clr_w      = bus_req.wr & sel_status & bus_req.wdata[`PPMI_STAT_FLAG_BIT];

   assign nxt_mask    = wr_mask ? bus_req.wdata[7:0] : pin_match_mask_ff;
   assign nxt_pattern = wr_pattern ? bus_req.wdata[7:0] : pin_match_pattern_ff;
   assign nxt_control = wr_control ? ppmi_pkg::ppmi_ctrl_t'(bus_req.wdata[2:0]) : pin_match_control_ff;
   assign nxt_irq_en  = wr_imask ? bus_req.wdata[`PPMI_IMASK_FLAG_BIT] : irq_en_ff;

   // Comparison: only bits chosen by the mask can make a difference.
   assign diff_w  = (sync_q ^ pin_match_pattern_ff) & pin_match_mask_ff;
   assign equal_w = diff_w == 8'h00;
   assign hit_w   = pin_match_control_ff.polarity ? ~equal_w : equal_w;
   // A pattern of all ones with not-equal selected turns any pressed key on a pin selected by the mask into a hit.
   assign match_w = pin_match_control_ff.active & hit_w;

   // Qualifier: the condition must be seen on more than six consecutive cycles.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      unique case (state_ff)
         ppmi_pkg::PPMI_ST_IDLE: begin
            if (match_w) begin
               nxt_state = ppmi_pkg::PPMI_ST_QUAL;
               nxt_cnt   = 3'h1;
            end
         end
         ppmi_pkg::PPMI_ST_QUAL: begin
            if (!match_w) begin
               nxt_state = ppmi_pkg::PPMI_ST_IDLE;
               nxt_cnt   = 3'h0;
            end else if (cnt_ff == HOLD_LAST) begin
               nxt_state = ppmi_pkg::PPMI_ST_HELD;
            end else begin
               nxt_cnt = cnt_ff + 3'h1;
            end
         end
         ppmi_pkg::PPMI_ST_HELD: begin
            if (!match_w) begin
               nxt_state = ppmi_pkg::PPMI_ST_IDLE;
               nxt_cnt   = 3'h0;
            end
         end
         default: begin
            nxt_state = ppmi_pkg::PPMI_ST_IDLE;
            nxt_cnt   = 3'h0;
         end
      endcase
   end

   // A held pattern keeps setting the flag, so a clear while a key is down is re-set at once.
   assign set_evt = match_w & (((state_ff == ppmi_pkg::PPMI_ST_QUAL) & (cnt_ff == HOLD_LAST)) |
                               (state_ff == ppmi_pkg::PPMI_ST_HELD));

   // Set wins over a clear in the same cycle.
   assign nxt_flag = set_evt | (pin_match_flag_ff & ~clr_w);

   // Read mux; unmapped addresses read as zero.
   assign rd_mux = ({32{sel_mask}}    & {24'h00_0000, pin_match_mask_ff}) |
                   ({32{sel_pattern}} & {24'h00_0000, pin_match_pattern_ff}) |
                   ({32{sel_control}} & {29'h0000_0000, pin_match_control_ff}) |
                   ({32{sel_status}}  & {31'h0000_0000, pin_match_flag_ff}) |
                   ({32{sel_imask}}   & {31'h0000_0000, irq_en_ff}) |
                   ({32{sel_port}}    & {24'h00_0000, sync_q}) |
                   ({32{sel_qual}}    & {27'h000_0000, cnt_ff, state_ff});
   assign nxt_rd_data = bus_req.rd ? rd_mux : 32'h0000_0000;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_match_mask_ff    <= `PPMI_RST_MASK;
         pin_match_pattern_ff <= `PPMI_RST_PATTERN;
         pin_match_control_ff <= ppmi_pkg::ppmi_ctrl_t'(`PPMI_RST_CONTROL);
         irq_en_ff            <= `PPMI_RST_IRQ_MASK;
      end else begin
         pin_match_mask_ff    <= nxt_mask;
         pin_match_pattern_ff <= nxt_pattern;
         pin_match_control_ff <= nxt_control;
         irq_en_ff            <= nxt_irq_en;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff          <= ppmi_pkg::PPMI_ST_IDLE;
         cnt_ff            <= 3'h0;
         pin_match_flag_ff <= 1'b0;
      end else begin
         state_ff          <= nxt_state;
         cnt_ff            <= nxt_cnt;
         pin_match_flag_ff <= nxt_flag;
      end
   end

   // Outputs are computed from next values so they track the flag and enables without lag.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_ff     <= 1'b0;
         wake_ff    <= 1'b0;
         rd_data_ff <= 32'h0000_0000;
      end else begin
         irq_ff     <= nxt_flag & nxt_irq_en;
         wake_ff    <= nxt_flag & nxt_irq_en & nxt_control.wake_en;
         rd_data_ff <= nxt_rd_data;
      end
   end

   assign irq      = irq_ff;
   assign wake_req = wake_ff;
   assign rd_data  = rd_data_ff;

   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_run7;
      match_w [*7];
   endsequence

   sequence s_clear_alone;
      clr_w && !set_evt;
   endsequence

   property p_run_sets;
      s_run7 |=> pin_match_flag_ff;
   endproperty
   a_run_sets: assert property (p_run_sets) else $error("flag not set after seven matching cycles");

   property p_no_early;
      $rose(pin_match_flag_ff) |-> $past(match_w, 1) && $past(match_w, 2) && $past(match_w, 3) &&
                                   $past(match_w, 4) && $past(match_w, 5) && $past(match_w, 6) &&
                                   $past(match_w, 7);
   endproperty
   a_no_early: assert property (p_no_early) else $error("flag set before match held seven cycles");

   property p_sense;
      $rose(pin_match_flag_ff) |-> ($past(pin_match_control_ff.polarity) ?
                                    ($past(diff_w) != 8'h00) : ($past(diff_w) == 8'h00));
   endproperty
   a_sense: assert property (p_sense) else $error("flag set against selected comparison sense");

   property p_mask_off;
      (pin_match_mask_ff == 8'h00) && pin_match_control_ff.polarity && !pin_match_flag_ff
         |=> !pin_match_flag_ff;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("flag set with every pin masked out");

   property p_active;
      $rose(pin_match_flag_ff) |-> $past(pin_match_control_ff.active, 1) &&
                                   $past(pin_match_control_ff.active, 7);
   endproperty
   a_active: assert property (p_active) else $error("flag set while function inactive");

   property p_sticky;
      pin_match_flag_ff && !clr_w |=> pin_match_flag_ff;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without a clear");

   property p_set_wins;
      set_evt && clr_w |=> pin_match_flag_ff;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a simultaneous set");

   property p_clear;
      s_clear_alone |=> !pin_match_flag_ff ##1 (irq == (pin_match_flag_ff && irq_en_ff));
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not remove flag");

   property p_irq_gate;
      $rose(pin_match_flag_ff) |-> (irq == irq_en_ff);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated by enable");

   property p_irq_off;
      !irq_en_ff |-> !irq && !wake_req;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("request raised while disabled");

   property p_wake;
      pin_match_flag_ff && irq_en_ff && pin_match_control_ff.wake_en |-> wake_req ##0 irq;
   endproperty
   a_wake: assert property (p_wake) else $error("wake request missing for enabled match");

   property p_held_flag;
      (state_ff == ppmi_pkg::PPMI_ST_HELD) |-> pin_match_flag_ff;
   endproperty
   a_held_flag: assert property (p_held_flag) else $error("qualified match without flag");

   property p_break_restarts;
      (state_ff == ppmi_pkg::PPMI_ST_QUAL) && !match_w
         |=> (state_ff == ppmi_pkg::PPMI_ST_IDLE) && (cnt_ff == 3'h0);
   endproperty
   a_break_restarts: assert property (p_break_restarts) else $error("broken match kept its count");

   property p_qual_count;
      (state_ff == ppmi_pkg::PPMI_ST_QUAL) |-> (cnt_ff != 3'h0) && (cnt_ff <= HOLD_LAST);
   endproperty
   a_qual_count: assert property (p_qual_count) else $error("qualifier count out of range");

   // The outputs are loaded from next values, so at every edge they equal the gating of the current flag.
   property p_irq_level;
      irq == (pin_match_flag_ff && irq_en_ff);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt differs from gated flag");

   property p_wake_level;
      wake_req == (pin_match_flag_ff && irq_en_ff && pin_match_control_ff.wake_en);
   endproperty
   a_wake_level: assert property (p_wake_level) else $error("wake request differs from gated flag");

endmodule
`default_nettype wire

// ---- tb/ppmi_keypad_model.sv ----
// Keypad partner model that presses a key pattern on the port for a set number of cycles.
`timescale 1ns/1ps
`default_nettype none
module ppmi_keypad_model (
   input  wire logic        clk_sys,
   input  wire logic        go,
   input  wire logic [7:0]  val,
   input  wire logic [15:0] len,
   output logic [7:0]       port_pins
);
   logic [15:0] cnt_ff;

   initial begin
      port_pins = 8'hFF;
      cnt_ff    = 16'h0000;
   end

   // A press holds the pattern for exactly len sampling edges, then the pull-ups take the lines high.
   always @(posedge clk_sys) begin
      if (go) begin
         port_pins <= val;
         cnt_ff    <= len;
      end else if (cnt_ff > 16'h0001) begin
         cnt_ff <= cnt_ff - 16'h0001;
      end else begin
         cnt_ff    <= 16'h0000;
         port_pins <= 8'hFF;
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb_port_pattern_match_interrupt.sv ----
// Self-checking testbench of the pin pattern match block with a keypad partner.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
   $display("ERROR %0t: mismatch got %h exp %h", $time, got, exp); end end
module tb_port_pattern_match_interrupt;
   logic                    clk_sys;
   logic                    rst;
   ppmi_pkg::ppmi_bus_req_t bus_req;
   logic [31:0]             rd_data;
   logic [7:0]              port_pins;
   logic                    irq;
   logic                    wake_req;
   logic                    go;
   logic [7:0]              val;
   logic [15:0]             len;
   int                      errors;
   int                      checked;

   ppmi_top uut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
                 .port_pins(port_pins), .irq(irq), .wake_req(wake_req));
   ppmi_keypad_model kp (.clk_sys(clk_sys), .go(go), .val(val), .len(len), .port_pins(port_pins));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus_req.addr  <= a;
      bus_req.wdata <= d;
      bus_req.wr    <= 1'b1;
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask

   // Read data are valid only in the cycle after the strobe and must drop to zero after it.
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      bus_req.addr <= a;
      bus_req.rd   <= 1'b1;
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1;
      `CHK(rd_data, e)
      @(posedge clk_sys);
      #1;
      `CHK(rd_data, 32'h0000_0000)
   endtask

   // Waits well past the synchroniser and qualifier delay after the press ends.
   task automatic press(input logic [7:0] v, input logic [15:0] l);
      @(posedge clk_sys);
      go  <= 1'b1;
      val <= v;
      len <= l;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (l + 12) @(posedge clk_sys);
   endtask

   task automatic outs(input logic i, input logic w);
      #1;
      `CHK(irq, i)
      `CHK(wake_req, w)
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      test_done;
   end

   initial begin
      rst     = 1'b1;
      bus_req = '0;
      go      = 1'b0;
      val     = 8'hFF;
      len     = 16'h0000;
      errors  = 0;
      checked = 0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(8'h00, 32'h0000_0000);
      rd_chk(8'h04, 32'h0000_00FF);
      rd_chk(8'h08, 32'h0000_0000);
      rd_chk(8'h0C, 32'h0000_0000);
      rd_chk(8'h10, 32'h0000_0000);
      rd_chk(8'h14, 32'h0000_00FF);
      rd_chk(8'h18, 32'h0000_0000);
      rd_chk(8'h1C, 32'h0000_0000);
      $display("test reset values done");
      wr(8'h00, 32'h0000_000F);
      wr(8'h04, 32'h0000_00FF);
      wr(8'h08, 32'h0000_0003);
      rd_chk(8'h00, 32'h0000_000F);
      press(8'h7F, 16'h0014);
      rd_chk(8'h0C, 32'h0000_0000);
      press(8'hFB, 16'h0006);
      rd_chk(8'h0C, 32'h0000_0000);
      press(8'hFB, 16'h0007);
      rd_chk(8'h0C, 32'h0000_0001);
      outs(1'b0, 1'b0);
      rd_chk(8'h0C, 32'h0000_0001);
      wr(8'h10, 32'h0000_0001);
      outs(1'b1, 1'b0);
      wr(8'h08, 32'h0000_0007);
      outs(1'b1, 1'b1);
      wr(8'h0C, 32'h0000_0001);
      outs(1'b0, 1'b0);
      rd_chk(8'h0C, 32'h0000_0000);
      $display("test key press done");
      wr(8'h04, 32'h0000_00A5);
      wr(8'h00, 32'h0000_00FF);
      wr(8'h08, 32'h0000_0005);
      press(8'hA4, 16'h000A);
      rd_chk(8'h0C, 32'h0000_0000);
      press(8'hA5, 16'h000A);
      rd_chk(8'h0C, 32'h0000_0001);
      outs(1'b1, 1'b1);
      wr(8'h0C, 32'h0000_0001);
      wr(8'h08, 32'h0000_0000);
      press(8'hA5, 16'h000A);
      rd_chk(8'h0C, 32'h0000_0000);
      outs(1'b0, 1'b0);
      $display("test equal sense done");
      wr(8'h04, 32'h0000_00A5);
      wr(8'h08, 32'h0000_0001);
      // A long press is started without waiting, so that the registers can be read while it is held.
      @(posedge clk_sys);
      go  <= 1'b1;
      val <= 8'hA5;
      len <= 16'h0028;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rd_chk(8'h14, 32'h0000_00A5);
      rd_chk(8'h18, 32'h0000_001A);
      wr(8'h0C, 32'h0000_0001);
      rd_chk(8'h0C, 32'h0000_0001);
      outs(1'b1, 1'b0);
      repeat (30) @(posedge clk_sys);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(8'h0C, 32'h0000_0000);
      rd_chk(8'h10, 32'h0000_0000);
      outs(1'b0, 1'b0);
      wr(8'h08, 32'h0000_0003);
      press(8'h00, 16'h000A);
      rd_chk(8'h0C, 32'h0000_0000);
      $display("test held match and reset done");
      test_done;
   end
endmodule
`default_nettype wire
